// ---- verilog/pcsw_words.sv ----
// Functional notes
// - code 0x10 returns full capacity, mAh or 10 mWh by units bit
// - code 0x11 returns run minutes up to 65534, 65535 when not draining
// - code 0x12 returns averaged run minutes by units bit, 65535 if not draining
// - code 0x13 returns averaged minutes to full, 65535 when not charging
// - code 0x14 returns requested charge current in mA, zero stops charger
// - code 0x15 gives charge voltage in mV, 65535 means constant current
// - status word: alarms 15,14,12,11,9,8; flags 7..4; error code 2..0
// - error code: ok,busy,reserved,unsupported,denied,overflow,size,unknown
// - alarm broadcast sends status word with all error code bits set
// - low capacity and low time alarms compare by units bit
// - overcharge flag set while overcharged, cleared by discharge or idle timeout
// - activity timeout in seconds is ten times the filter setting
// - stop-charge flag set on out-of-range charge parameter or termination
// - stop-charge flag clears when condition ends or charging stops
// - over-temperature flag follows temperature at or above the ceiling
// - config-loaded flag set by valid load, cleared by improper load
`timescale 1ns/1ps
`default_nettype none

module pcsw_words
  import pcsw_pkg::*;
#(
  parameter int CYC_PER_SEC = SEC_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic busy_in,
  input wire logic ovf_evt,
  input wire logic cap_mode,
  input wire logic [15:0] full_cap_amp,
  input wire logic [15:0] full_cap_pow,
  input wire logic [15:0] run_left_amp,
  input wire logic [15:0] run_left_pow,
  input wire logic [15:0] avg_left_amp,
  input wire logic [15:0] avg_left_pow,
  input wire logic [15:0] avg_full_in,
  input wire logic [15:0] chg_amps_in,
  input wire logic chg_volts_ld,
  input wire logic [15:0] chg_volts_in,
  input wire logic [15:0] rem_cap_amp,
  input wire logic [15:0] rem_cap_pow,
  input wire logic [15:0] cap_alarm_amp,
  input wire logic [15:0] cap_alarm_pow,
  input wire logic [15:0] time_alarm,
  input wire logic chg_act,
  input wire logic dis_act,
  input wire logic over_limit,
  input wire logic chg_param_bad,
  input wire logic chg_term,
  input wire logic [15:0] temp_in,
  input wire logic [15:0] temp_ceiling,
  input wire logic cfg_load_ok,
  input wire logic cfg_load_bad,
  input wire logic stop_dis_in,
  input wire logic full_in,
  input wire logic empty_in,
  input wire logic [FILT_W-1:0] filt_val,
  output logic rd_valid,
  output logic [15:0] rd_data,
  output logic alarm_valid,
  output logic [15:0] alarm_word,
  output logic draining_flag
);

  typedef struct packed {
    logic [15:0] rd_data;
    logic rd_valid;
    logic [2:0] err;
    logic [15:0] volts;
    logic drain;
    logic over_chg;
    logic stop_chg;
    logic over_temp;
    logic cfg_ok;
    logic cap_low;
    logic time_low;
    logic [IDLE_W-1:0] idle_sec;
    logic [15:0] bc_word;
    logic bc_valid;
  } pcsw_state_t;

  pcsw_state_t s_ff;
  pcsw_state_t nxt_s;
  logic sec_tick;
  logic timeout;
  logic [15:0] status_now;

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  function automatic logic [15:0] pick(input logic mode,
                                       input logic [15:0] amp,
                                       input logic [15:0] pow);
    pick = mode ? pow : amp;
  endfunction

  // valid minutes never reach the invalid marker
  function automatic logic [15:0] clamp_time(input logic ok,
                                             input logic [15:0] v);
    if (!ok) begin
      clamp_time = TIME_INVALID;
    end else if (v == TIME_INVALID) begin
      clamp_time = TIME_MAX;
    end else begin
      clamp_time = v;
    end
  endfunction

  function automatic logic [15:0] build_status(input pcsw_state_t st,
                                               input logic sd,
                                               input logic fu,
                                               input logic em);
    logic [15:0] w;
    w = 16'h0000;
    w[BIT_OVER_CHG] = st.over_chg;
    w[BIT_STOP_CHG] = st.stop_chg;
    w[BIT_OVER_TEMP] = st.over_temp;
    w[BIT_STOP_DIS] = sd;
    w[BIT_CAP_LOW] = st.cap_low;
    w[BIT_TIME_LOW] = st.time_low;
    w[BIT_CFG_OK] = st.cfg_ok;
    w[BIT_DRAIN] = st.drain;
    w[BIT_FULL] = fu;
    w[BIT_EMPTY] = em;
    w[2:0] = st.err;
    build_status = w & ~RSVD_MASK;
  endfunction

  // ---------------------------------------------------------------
  // second tick for the activity filter
  // ---------------------------------------------------------------
  pcsw_sec_tick #(
    .CYC_PER_SEC(CYC_PER_SEC)
  ) u_tick (
    .mclk(mclk),
    .rstn(rstn),
    .tick(sec_tick)
  );

  // idle limit is ten seconds per filter step
  assign timeout = s_ff.idle_sec >=
                   IDLE_W'(FILT_MULT * int'(filt_val));
  assign status_now = build_status(s_ff, stop_dis_in, full_in,
                                   empty_in);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    nxt_s.rd_valid = 1'b0;
    nxt_s.bc_valid = 1'b0;

    // seconds without any charge or discharge activity
    if (chg_act || dis_act) begin
      nxt_s.idle_sec = '0;
    end else if (sec_tick && !timeout) begin
      nxt_s.idle_sec = s_ff.idle_sec + IDLE_W'(1);
    end

    // charging seen clears, discharge or idle timeout sets
    if (chg_act) begin
      nxt_s.drain = 1'b0;
    end else if (dis_act || timeout) begin
      nxt_s.drain = 1'b1;
    end

    // overcharge flag, set wins over clear
    if (chg_act && over_limit) begin
      nxt_s.over_chg = 1'b1;
    end else if (dis_act || timeout) begin
      nxt_s.over_chg = 1'b0;
    end

    // stop-charge follows condition while charging lasts
    nxt_s.stop_chg = (chg_param_bad || chg_term) &&
                     !(nxt_s.drain);
    nxt_s.over_temp = temp_in >= temp_ceiling;

    // config load flag, valid load wins
    if (cfg_load_ok) begin
      nxt_s.cfg_ok = 1'b1;
    end else if (cfg_load_bad) begin
      nxt_s.cfg_ok = 1'b0;
    end

    // low alarms judged in the selected units
    nxt_s.cap_low = pick(cap_mode, rem_cap_amp, rem_cap_pow) <
                    pick(cap_mode, cap_alarm_amp, cap_alarm_pow);
    nxt_s.time_low = s_ff.drain &&
                     (pick(cap_mode, avg_left_amp, avg_left_pow) <
                      time_alarm);

    // engine may refresh the requested voltage
    if (chg_volts_ld) begin
      nxt_s.volts = chg_volts_in;
    end

    // command handling
    if (cmd_valid) begin
      if (busy_in) begin
        nxt_s.err = ERR_BUSY;
      end else if (cmd_write) begin
        if (cmd_code == CMD_CHG_VOLTS) begin
          nxt_s.volts = cmd_wdata;
          nxt_s.err = ERR_OK;
        end else if (cmd_code >= CMD_FULL_CAP &&
                     cmd_code <= CMD_STATUS) begin
          nxt_s.err = ERR_DENIED;
        end else begin
          nxt_s.err = ERR_UNSUP;
        end
      end else begin
        nxt_s.rd_valid = 1'b1;
        nxt_s.err = ERR_OK;
        case (cmd_code)
          CMD_FULL_CAP: begin
            nxt_s.rd_data = pick(cap_mode, full_cap_amp,
                                 full_cap_pow);
          end
          CMD_RUN_LEFT: begin
            nxt_s.rd_data = clamp_time(s_ff.drain,
              pick(cap_mode, run_left_amp, run_left_pow));
          end
          CMD_AVG_LEFT: begin
            nxt_s.rd_data = clamp_time(s_ff.drain,
              pick(cap_mode, avg_left_amp, avg_left_pow));
          end
          CMD_AVG_FULL: begin
            nxt_s.rd_data = clamp_time(!s_ff.drain, avg_full_in);
          end
          CMD_CHG_AMPS: begin
            nxt_s.rd_data = chg_amps_in;
          end
          CMD_CHG_VOLTS: begin
            nxt_s.rd_data = s_ff.volts;
          end
          CMD_STATUS: begin
            nxt_s.rd_data = status_now;
            nxt_s.err = s_ff.err;
          end
          default: begin
            nxt_s.rd_valid = 1'b0;
            nxt_s.err = ERR_UNSUP;
          end
        endcase
      end
    end

    // overflow reported by the engine outranks command result
    if (ovf_evt) begin
      nxt_s.err = ERR_OVF;
    end

    // broadcast when any alarm except stop-discharge newly rises
    if (|(build_status(nxt_s, stop_dis_in, full_in, empty_in) &
          ~status_now & ALARM_MASK)) begin
      nxt_s.bc_valid = 1'b1;
      nxt_s.bc_word = build_status(nxt_s, stop_dis_in, full_in, empty_in)
                      | {13'h0000, ERR_ALL_ONES};
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      s_ff <= '0;
      s_ff.volts <= VOLTS_RST;
      s_ff.drain <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign rd_valid = s_ff.rd_valid;
  assign rd_data = s_ff.rd_data;
  assign alarm_valid = s_ff.bc_valid;
  assign alarm_word = s_ff.bc_word;
  assign draining_flag = s_ff.drain;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  run_invalid_a: assert property (
    (cmd_valid && !cmd_write && !busy_in && cmd_code == CMD_RUN_LEFT &&
     !s_ff.drain) |=> (rd_valid && rd_data == 16'hFFFF))
    else $error("run time not invalid while not draining");
  full_invalid_a: assert property (
    (cmd_valid && !cmd_write && !busy_in && cmd_code == CMD_AVG_FULL &&
     s_ff.drain) |=> (rd_valid && rd_data == 16'hFFFF))
    else $error("time to full not invalid while not charging");
  run_range_a: assert property (
    (cmd_valid && !cmd_write && !busy_in && cmd_code == CMD_AVG_LEFT &&
     s_ff.drain) |=> (rd_valid && rd_data != 16'hFFFF))
    else $error("averaged run time out of range while draining");
  status_rsvd_a: assert property (
    (cmd_valid && !cmd_write && !busy_in && cmd_code == CMD_STATUS)
    |=> (rd_valid && (rd_data & 16'h2408) == 16'h0000))
    else $error("reserved status bits not zero");
  bcast_err_a: assert property (
    alarm_valid |-> (alarm_word[2:0] == 3'h7 &&
                     alarm_word[15] == s_ff.over_chg &&
                     alarm_word[12] == s_ff.over_temp))
    else $error("broadcast word not status with error bits set");
  overchg_clear_a: assert property (
    (s_ff.over_chg && dis_act && !chg_act) |=> !s_ff.over_chg)
    else $error("overcharge flag not cleared by discharge");
  over_temp_a: assert property (
    (temp_in >= temp_ceiling) |=> s_ff.over_temp)
    else $error("over temperature flag not set");
  cfg_loaded_a: assert property (
    cfg_load_ok |=> s_ff.cfg_ok)
    else $error("config flag not set after valid load");
  write_denied_a: assert property (
    (cmd_valid && cmd_write && !busy_in && !ovf_evt &&
     cmd_code == CMD_FULL_CAP) |=> (s_ff.err == 3'h4 && !rd_valid))
    else $error("write to read-only word not denied");
  volts_write_a: assert property (
    (cmd_valid && cmd_write && !busy_in && cmd_code == CMD_CHG_VOLTS)
    |=> (s_ff.volts == $past(cmd_wdata)))
    else $error("written charge voltage not stored");

endmodule

`default_nettype wire

// ---- shared/pcsw_pkg.sv ----
package pcsw_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int ONE_SEC_S = 1;
  localparam int SEC_CYCLES = ONE_SEC_S * CLK_HZ;
  localparam int FILT_MULT = 10;
  localparam int FILT_W = 8;
  localparam int IDLE_W = 12;

  // ---------------------------------------------------------------
  // command codes (read word / write word)
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_FULL_CAP = 8'h10;
  localparam logic [7:0] CMD_RUN_LEFT = 8'h11;
  localparam logic [7:0] CMD_AVG_LEFT = 8'h12;
  localparam logic [7:0] CMD_AVG_FULL = 8'h13;
  localparam logic [7:0] CMD_CHG_AMPS = 8'h14;
  localparam logic [7:0] CMD_CHG_VOLTS = 8'h15;
  localparam logic [7:0] CMD_STATUS = 8'h16;

  // ---------------------------------------------------------------
  // status word layout
  // ---------------------------------------------------------------
  localparam int BIT_OVER_CHG = 15;
  localparam int BIT_STOP_CHG = 14;
  localparam int BIT_OVER_TEMP = 12;
  localparam int BIT_STOP_DIS = 11;
  localparam int BIT_CAP_LOW = 9;
  localparam int BIT_TIME_LOW = 8;
  localparam int BIT_CFG_OK = 7;
  localparam int BIT_DRAIN = 6;
  localparam int BIT_FULL = 5;
  localparam int BIT_EMPTY = 4;
  localparam logic [15:0] RSVD_MASK = 16'h2408;
  localparam logic [15:0] ALARM_MASK = 16'hDB00;
  localparam logic [15:0] TIME_INVALID = 16'hFFFF;
  localparam logic [15:0] TIME_MAX = 16'hFFFE;
  localparam logic [15:0] VOLTS_RST = 16'h0000;

  // ---------------------------------------------------------------
  // error codes
  // ---------------------------------------------------------------
  localparam logic [2:0] ERR_OK = 3'h0;
  localparam logic [2:0] ERR_BUSY = 3'h1;
  localparam logic [2:0] ERR_RSVD_CMD = 3'h2;
  localparam logic [2:0] ERR_UNSUP = 3'h3;
  localparam logic [2:0] ERR_DENIED = 3'h4;
  localparam logic [2:0] ERR_OVF = 3'h5;
  localparam logic [2:0] ERR_BAD_SIZE = 3'h6;
  localparam logic [2:0] ERR_UNKNOWN = 3'h7;
  localparam logic [2:0] ERR_ALL_ONES = 3'h7;

endpackage

// ---- verilog/pcsw_sec_tick.sv ----
`timescale 1ns/1ps
`default_nettype none

module pcsw_sec_tick
  import pcsw_pkg::*;
#(
  parameter int CYC_PER_SEC = SEC_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  output logic tick
);

  localparam int CW = $clog2(CYC_PER_SEC + 1);
  localparam logic [CW-1:0] LAST = CW'(CYC_PER_SEC - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } pcsw_tick_st_t;

  pcsw_tick_st_t st_ff;
  pcsw_tick_st_t nxt_st;

  // ---------------------------------------------------------------
  // one-cycle pulse once per second
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (st_ff.cnt == LAST) begin
      nxt_st.cnt = '0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + CW'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick = st_ff.tick;

endmodule

`default_nettype wire

// ---- verif/pcsw_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// host and charger stand-in on the command port
// ---------------------------------------------------------------
module pcsw_host_model
  import pcsw_pkg::*;
(
  input wire logic mclk,
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata,
  input wire logic rd_valid,
  input wire logic [15:0] rd_data,
  output logic cv_src,
  output logic cc_src
);
  // idle port, charger in normal regulation
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
    cv_src = 1'b0;
    cc_src = 1'b0;
  end

  // one word transfer; answer is due one edge after the take
  task automatic xfer(input logic wr, input logic [7:0] code,
    input logic [15:0] wd, output logic got, output logic [15:0] rd);
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_code = code;
    cmd_wdata = wd;
    @(negedge mclk);
    got = rd_valid;
    rd = rd_data;
    cmd_valid = 1'b0;
    cmd_code = ~code; // released lines do not keep the old value
    cmd_wdata = ~wd;
    // charger picks its operating point from the requests
    if (got && code == CMD_CHG_AMPS) cv_src = (rd == 16'hFFFF);
    if (got && code == CMD_CHG_VOLTS) cc_src = (rd == 16'hFFFF);
  endtask
endmodule
`default_nettype wire

// ---- verif/pcsw_words_bench.sv ----
`timescale 1ns/1ps
`default_nettype none

module pcsw_words_bench
  import pcsw_pkg::*;
;
  // ---------------------------------------------------------------
  // stimulus and wiring
  // ---------------------------------------------------------------
  localparam int CPS = 20;
  int error_cnt = 0;
  int cmp_count = 0;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic cmd_valid, cmd_write, rd_valid, alarm_valid, draining_flag;
  logic cv_src, cc_src;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, rd_data, alarm_word;
  logic busy_in = 1'b0, ovf_evt = 1'b0, cap_mode = 1'b0;
  logic chg_volts_ld = 1'b0, chg_act = 1'b0, dis_act = 1'b0;
  logic over_limit = 1'b0, chg_term = 1'b0, chg_param_bad = 1'b0;
  logic cfg_load_ok = 1'b0, cfg_load_bad = 1'b0, stop_dis_in = 1'b0;
  logic full_in = 1'b0, empty_in = 1'b0;
  logic [FILT_W-1:0] filt_val = 8'h02;
  logic [15:0] full_cap_amp = 16'h1234, full_cap_pow = 16'h0ABC;
  logic [15:0] run_left_amp = 16'hFFFF, run_left_pow = 16'h0321;
  logic [15:0] avg_left_amp = 16'h0456, avg_left_pow = 16'h0789;
  logic [15:0] avg_full_in = 16'h0222, chg_amps_in = 16'hFFFF;
  logic [15:0] chg_volts_in = 16'h3A98, time_alarm = 16'h0500;
  logic [15:0] rem_cap_amp = 16'h0100, rem_cap_pow = 16'h0900;
  logic [15:0] cap_alarm_amp = 16'h0200, cap_alarm_pow = 16'h0800;
  logic [15:0] temp_in = 16'h0BB8, temp_ceiling = 16'h0C00;

  always #12.5 mclk = ~mclk;

  pcsw_words #(.CYC_PER_SEC(CPS)) i_dut (
    .mclk, .rstn, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata,
    .busy_in, .ovf_evt, .cap_mode, .full_cap_amp, .full_cap_pow,
    .run_left_amp, .run_left_pow, .avg_left_amp, .avg_left_pow,
    .avg_full_in, .chg_amps_in, .chg_volts_ld, .chg_volts_in,
    .rem_cap_amp, .rem_cap_pow, .cap_alarm_amp, .cap_alarm_pow,
    .time_alarm, .chg_act, .dis_act, .over_limit, .chg_param_bad,
    .chg_term, .temp_in, .temp_ceiling, .cfg_load_ok, .cfg_load_bad,
    .stop_dis_in, .full_in, .empty_in, .filt_val, .rd_valid, .rd_data,
    .alarm_valid, .alarm_word, .draining_flag
  );

  pcsw_host_model i_host (
    .mclk, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata, .rd_valid,
    .rd_data, .cv_src, .cc_src
  );

  // ---------------------------------------------------------------
  // shared helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic pulse(ref logic s);
    @(negedge mclk);
    s = 1'b1;
    @(negedge mclk);
    s = 1'b0;
  endtask

  task automatic rd(input logic [7:0] code, input logic [15:0] exp);
    logic g;
    logic [15:0] d;
    i_host.xfer(1'b0, code, 16'h0000, g, d);
    chk(g, 16'h0001);
    chk(d, exp);
  endtask

  // status read: masked compare, reserved bits always zero
  task automatic st(input logic [15:0] m, input logic [15:0] exp);
    logic g;
    logic [15:0] d;
    i_host.xfer(1'b0, CMD_STATUS, 16'h0000, g, d);
    chk(d & m, exp);
    chk(d & RSVD_MASK, 16'h0000);
  endtask

  task automatic tally_and_finish();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // per-mode word reads while draining, then while charging
  task automatic t_words();
    for (int m = 0; m < 2; m++) begin
      cap_mode = m[0];
      rd(CMD_FULL_CAP, m ? full_cap_pow : full_cap_amp);
      rd(CMD_RUN_LEFT, m ? run_left_pow : TIME_MAX);
      rd(CMD_AVG_LEFT, m ? avg_left_pow : avg_left_amp);
      rd(CMD_AVG_FULL, TIME_INVALID);
      rd(CMD_CHG_AMPS, chg_amps_in);
      chk(cv_src, 16'h0001);
      st(16'h0340, m ? 16'h0040 : 16'h0340);
    end
    chg_act = 1'b1;
    chg_amps_in = 16'h0000;
    rd(CMD_RUN_LEFT, TIME_INVALID);
    rd(CMD_AVG_LEFT, TIME_INVALID);
    rd(CMD_AVG_FULL, avg_full_in);
    rd(CMD_CHG_AMPS, 16'h0000);
    chk(cv_src, 16'h0000);
    chk(draining_flag, 16'h0000);
    chg_act = 1'b0;
    dis_act = 1'b1;
    cyc(2);
    dis_act = 1'b0;
  endtask

  // voltage request: reset, host write, local load
  task automatic t_volts();
    logic g;
    logic [15:0] d;
    rd(CMD_CHG_VOLTS, VOLTS_RST);
    i_host.xfer(1'b1, CMD_CHG_VOLTS, 16'hFFFF, g, d);
    rd(CMD_CHG_VOLTS, 16'hFFFF);
    chk(cc_src, 16'h0001);
    pulse(chg_volts_ld);
    rd(CMD_CHG_VOLTS, chg_volts_in);
  endtask

  // each command outcome leaves its code in the status word
  task automatic t_errors();
    logic g;
    logic [15:0] d;
    logic [7:0] code [6] = '{8'h10, 8'h15, 8'h20, 8'h30, 8'h10, 8'h20};
    logic wr [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    logic [2:0] err [6] = '{ERR_DENIED, ERR_OK, ERR_UNSUP, ERR_UNSUP,
      ERR_BUSY, ERR_OVF};
    for (int i = 0; i < 6; i++) begin
      busy_in = (i == 4);
      ovf_evt = (i == 5);
      i_host.xfer(wr[i], code[i], 16'h1111, g, d);
      busy_in = 1'b0;
      ovf_evt = 1'b0;
      chk(g, 16'h0000);
      st(16'h0007, {13'h0000, err[i]});
    end
  endtask

  // at-ceiling temperature raises the broadcast with code bits forced
  task automatic t_alarm();
    int i;
    temp_in = temp_ceiling;
    for (i = 0; i < 4 && alarm_valid !== 1'b1; i++) @(negedge mclk);
    chk(alarm_valid, 16'h0001);
    chk(alarm_word & 16'h1007, 16'h1007);
    st(16'h1007, 16'h1005);
    temp_in = 16'h0BB8;
    st(16'h1000, 16'h0000);
  endtask

  // status bit positions and configuration load flag
  task automatic t_flags();
    stop_dis_in = 1'b1;
    full_in = 1'b1;
    empty_in = 1'b1;
    pulse(cfg_load_ok);
    st(16'h08F0, 16'h08F0);
    stop_dis_in = 1'b0;
    full_in = 1'b0;
    empty_in = 1'b0;
    pulse(cfg_load_bad);
    st(16'h08B0, 16'h0000);
  endtask

  // overcharge and stop-charge flags, idle timeout of 10 x filter
  task automatic t_charge();
    int n;
    chg_act = 1'b1;
    over_limit = 1'b1;
    chg_param_bad = 1'b1;
    st(16'hC000, 16'hC000);
    chg_param_bad = 1'b0;
    st(16'h4000, 16'h0000);
    chg_term = 1'b1;
    st(16'h4000, 16'h4000);
    chg_act = 1'b0;
    over_limit = 1'b0;
    dis_act = 1'b1;
    st(16'hC000, 16'h0000);
    dis_act = 1'b0;
    chg_term = 1'b0;
    chg_act = 1'b1;
    over_limit = 1'b1;
    cyc(2);
    chg_act = 1'b0;
    over_limit = 1'b0;
    cyc(19 * CPS - 2);
    chk(draining_flag, 16'h0000);
    for (n = 0; n < 3 * CPS && draining_flag !== 1'b1; n++) cyc(1);
    if (n == 3 * CPS) begin
      error_cnt++;
      tally_and_finish();
    end
    st(16'h8040, 16'h0040);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(negedge mclk);
    rstn = 1'b1;
    t_words();
    t_volts();
    t_errors();
    t_alarm();
    t_flags();
    t_charge();
    tally_and_finish();
  end
endmodule
`default_nettype wire
